// file: hdl/lbus_pkg.sv
package lbus_pkg;
    localparam int addr_w = 32;
    localparam int offset_w = 12;
    localparam int code_w = 4;
    localparam int beats_w = 3;
    localparam int line_offset_w = 4;
    localparam logic [beats_w-1:0] read_beats = 3'h4;
    localparam logic [beats_w-1:0] max_write_beats = 3'h4;
    localparam logic [beats_w-1:0] min_burst_beats = 3'h2;
    localparam logic [beats_w-1:0] single_beat = 3'h1;
    localparam logic [1:0] grant_wait_clocks = 2'h1;
    localparam logic strap_first_family = 1'b0;

    // one master transaction requested by the bridge core
    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [code_w-1:0] code;
        logic read;
        logic [beats_w-1:0] beats;
    } master_req_t;

    // slave address phase as seen by the bridge core
    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [offset_w-1:0] offset;
        logic read;
    } slave_addr_t;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_request = 3'b001,
        st_grant_wait = 3'b010,
        st_address = 3'b011,
        st_data = 3'b100,
        st_negate = 3'b101
    } master_state_t;
endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; the output moves only when stages two and three agree
module pin_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    logic meta;
    logic stage2;
    logic stage3;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            meta <= pin;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            level <= RESET_VALUE;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule // pin_sync

// file: hdl/local_bus_address_arbitration_port.sv
`timescale 1ns/1ps
module local_bus_address_arbitration_port
    import lbus_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic async_arbitration,
    input wire logic master_start,
    input wire lbus_pkg::master_req_t master_req,
    input wire logic beat_done,
    output logic master_busy,
    output logic master_error,
    output logic master_done,
    input wire logic [lbus_pkg::addr_w-1:0] addr_in,
    output logic [lbus_pkg::addr_w-1:0] addr_out,
    output logic addr_oe,
    output logic [lbus_pkg::code_w-1:0] address_type,
    output logic address_type_oe,
    input wire logic transfer_start_n,
    input wire logic read_write_in,
    output logic read_write_out,
    input wire logic bus_grant_n,
    output logic bus_request_n,
    input wire logic bus_busy_n_in,
    output logic bus_busy_n_out,
    output logic bus_busy_n_oe,
    input wire logic burst_data_in_progress_n_in,
    output logic burst_data_in_progress_n_out,
    output logic burst_data_in_progress_n_oe,
    input wire logic transfer_error_ack_n_in,
    output logic transfer_error_ack_n_out,
    output logic transfer_error_ack_n_oe,
    input wire logic slave_selected,
    input wire logic slave_error,
    input wire logic slave_end,
    output logic slave_addr_valid,
    output lbus_pkg::slave_addr_t slave_addr,
    output logic slave_last_beat_next,
    output logic second_family
);
    import lbus_pkg::*;

    master_state_t state;
    master_req_t cur;
    logic [beats_w-1:0] beats_left;
    logic [1:0] grant_wait;
    logic grant_sync;
    logic busy_sync;
    logic grant_seen;
    logic busy_seen;
    logic slave_driving;
    logic error_in;
    logic progress_in;
    logic data_end;
    logic next_bus_request_n;

    // grant and busy pins from the far side cross through four flops in the synchronous arbitration mode
    pin_sync #(.RESET_VALUE(1'b1)) grant_sync_i (
        .mclk(mclk),
        .nrst(nrst),
        .pin(bus_grant_n),
        .level(grant_sync)
    );

    pin_sync #(.RESET_VALUE(1'b1)) busy_sync_i (
        .mclk(mclk),
        .nrst(nrst),
        .pin(bus_busy_n_in),
        .level(busy_sync)
    );

    // async mode takes the pins on the edge; synchronous mode waits for the filter
    always_comb begin
        if (async_arbitration) begin
            grant_seen = !bus_grant_n;
            busy_seen = !bus_busy_n_in;
        end else begin
            grant_seen = !grant_sync;
            busy_seen = !busy_sync;
        end
    end

    // shared bus lines sampled once per edge; the far party keeps them stable around the edge
    assign error_in = !transfer_error_ack_n_in;
    assign progress_in = !burst_data_in_progress_n_in;

    // last data edge of a master transfer, normal end or error
    assign data_end = state == st_data && (error_in || (beat_done && beats_left == single_beat));

    // strap followed on every reset edge while our progress driver is off; frozen at release
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            second_family <= burst_data_in_progress_n_in != strap_first_family;
        end
    end

    // master arbitration and address phase
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= st_idle;
            cur <= '0;
            grant_wait <= 2'h0;
        end else begin
            case (state)
                st_idle: begin
                    if (master_start) begin
                        cur <= master_req;
                        if (master_req.read) begin
                            cur.beats <= (master_req.beats > single_beat) ? read_beats : single_beat;
                            // cacheline alignment of four-beat reads
                            cur.addr <= (master_req.beats > single_beat) ?
                                {master_req.addr[addr_w-1:line_offset_w], {line_offset_w{1'b0}}} :
                                master_req.addr;
                        end else if (master_req.beats > max_write_beats) begin
                            cur.beats <= max_write_beats;
                        end else if (master_req.beats == '0) begin
                            cur.beats <= single_beat;
                        end
                        state <= st_request;
                    end
                end
                st_request: begin
                    // grant alone is not enough; the previous owner must have let go
                    if (grant_seen && !busy_seen) begin
                        grant_wait <= grant_wait_clocks;
                        state <= st_grant_wait;
                    end
                end
                st_grant_wait: begin
                    if (grant_wait > 2'h1) begin
                        grant_wait <= grant_wait - 2'h1;
                    end else if (second_family || grant_wait == 2'h1) begin
                        state <= st_address;
                    end
                end
                st_address: begin
                    state <= st_data;
                end
                st_data: begin
                    if (data_end) begin
                        state <= st_negate;
                    end
                end
                st_negate: begin
                    state <= st_idle;
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            beats_left <= '0;
        end else if (state == st_address) begin
            beats_left <= cur.beats;
        end else if (state == st_data && beat_done && beats_left != '0) begin
            beats_left <= beats_left - single_beat;
        end
    end

    // request held from the start pulse until grant is seen with the bus free
    always_comb begin
        next_bus_request_n = 1'b1;
        case (state)
            st_idle: begin
                if (master_start) begin
                    next_bus_request_n = 1'b0;
                end
            end
            st_request: begin
                if (!(grant_seen && !busy_seen)) begin
                    next_bus_request_n = 1'b0;
                end
            end
            default: begin
                next_bus_request_n = 1'b1;
            end
        endcase
    end

    // request line, launched from the clock edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bus_request_n <= 1'b1;
        end else begin
            bus_request_n <= next_bus_request_n;
        end
    end

    // busy asserted while owning, negated actively for one clock, then released
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bus_busy_n_out <= 1'b1;
            bus_busy_n_oe <= 1'b0;
        end else begin
            case (state)
                st_grant_wait: begin
                    bus_busy_n_out <= 1'b1;
                    bus_busy_n_oe <= 1'b0;
                end
                st_address, st_data: begin
                    bus_busy_n_out <= 1'b0;
                    bus_busy_n_oe <= 1'b1;
                end
                st_negate: begin
                    bus_busy_n_out <= 1'b1;
                    bus_busy_n_oe <= 1'b1;
                end
                default: begin
                    bus_busy_n_out <= 1'b1;
                    bus_busy_n_oe <= 1'b0;
                end
            endcase
        end
    end

    // address, type and direction launched after the edge while master
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            addr_out <= '0;
            addr_oe <= 1'b0;
            address_type <= '0;
            address_type_oe <= 1'b0;
            read_write_out <= 1'b1;
        end else if (state == st_address || state == st_data) begin
            addr_out <= cur.addr;
            addr_oe <= 1'b1;
            address_type <= cur.code;
            address_type_oe <= 1'b1;
            read_write_out <= cur.read;
        end else begin
            addr_oe <= 1'b0;
            address_type_oe <= 1'b0;
        end
    end

    // progress line only on write bursts, asserted until the second-last beat completes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            burst_data_in_progress_n_out <= 1'b1;
            burst_data_in_progress_n_oe <= 1'b0;
        end else if (state == st_address) begin
            burst_data_in_progress_n_oe <= 1'b1;
            burst_data_in_progress_n_out <= !(!cur.read && cur.beats >= min_burst_beats);
        end else if (state == st_data) begin
            burst_data_in_progress_n_oe <= 1'b1;
            if (beat_done && beats_left <= min_burst_beats) begin
                burst_data_in_progress_n_out <= 1'b1;
            end
        end else begin
            burst_data_in_progress_n_out <= 1'b1;
            burst_data_in_progress_n_oe <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            master_busy <= 1'b0;
        end else begin
            master_busy <= state != st_idle || master_start;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            master_done <= 1'b0;
        end else begin
            master_done <= data_end;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            master_error <= 1'b0;
        end else begin
            master_error <= data_end && error_in;
        end
    end

    // slave address capture on the transfer start edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            slave_addr_valid <= 1'b0;
        end else begin
            slave_addr_valid <= !transfer_start_n && !addr_oe;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            slave_addr <= '0;
        end else if (!transfer_start_n && !addr_oe) begin
            slave_addr.addr <= addr_in;
            slave_addr.offset <= addr_in[offset_w-1:0];
            slave_addr.read <= read_write_in;
        end
    end

    // slave sees the external master flag the second-last beat
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            slave_last_beat_next <= 1'b0;
        end else begin
            slave_last_beat_next <= !addr_oe && progress_in;
        end
    end

    // error ack: driven only as selected slave, one clock of negation before release
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            slave_driving <= 1'b0;
            transfer_error_ack_n_out <= 1'b1;
            transfer_error_ack_n_oe <= 1'b0;
        end else if (slave_selected && !addr_oe && !slave_end) begin
            slave_driving <= 1'b1;
            transfer_error_ack_n_out <= !slave_error;
            transfer_error_ack_n_oe <= 1'b1;
        end else if (slave_driving) begin
            slave_driving <= 1'b0;
            transfer_error_ack_n_out <= 1'b1;
            transfer_error_ack_n_oe <= 1'b1;
        end else begin
            transfer_error_ack_n_out <= 1'b1;
            transfer_error_ack_n_oe <= 1'b0;
        end
    end
endmodule // local_bus_address_arbitration_port

// file: dv/lbus_port_sva.sv
`timescale 1ns/1ps
module lbus_port_sva
    import lbus_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic master_start,
    input wire logic master_busy,
    input wire logic master_done,
    input wire logic [lbus_pkg::addr_w-1:0] addr_in,
    input wire logic addr_oe,
    input wire logic address_type_oe,
    input wire logic transfer_start_n,
    input wire logic bus_grant_n,
    input wire logic bus_request_n,
    input wire logic bus_busy_n_in,
    input wire logic bus_busy_n_out,
    input wire logic bus_busy_n_oe,
    input wire logic transfer_error_ack_n_out,
    input wire logic transfer_error_ack_n_oe,
    input wire logic slave_addr_valid,
    input wire lbus_pkg::slave_addr_t slave_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_addr_with_busy: assert property (addr_oe |-> bus_busy_n_oe && address_type_oe)
        else $error("address driven without busy or type");
    a_busy_asserted: assert property ($rose(bus_busy_n_oe) |-> !bus_busy_n_out)
        else $error("busy enabled but not asserted");
    a_busy_negated: assert property ($fell(bus_busy_n_oe) |-> $past(bus_busy_n_out))
        else $error("busy released without negation");
    a_grant_wait: assert property ($rose(bus_busy_n_oe) |-> !$past(bus_grant_n, 2))
        else $error("busy asserted too soon after grant");
    a_start_when_free: assert property ($rose(addr_oe) |-> $past(bus_busy_n_in))
        else $error("mastership taken while bus busy");
    a_request_edge: assert property (master_start && !master_busy |=> !bus_request_n)
        else $error("bus request not asserted");
    a_tea_negated: assert property ($fell(transfer_error_ack_n_oe) |-> $past(transfer_error_ack_n_out))
        else $error("error ack released without negation");
    a_tea_as_slave: assert property (transfer_error_ack_n_oe |-> !addr_oe)
        else $error("error ack driven while master");
    a_slave_capture: assert property (!transfer_start_n && !addr_oe |=> slave_addr_valid && slave_addr.addr == $past(addr_in))
        else $error("slave address not captured");
    a_offset_low: assert property (slave_addr_valid |-> slave_addr.offset == slave_addr.addr[11:0] && $past(!transfer_start_n))
        else $error("offset wrong or stray valid");
    c_master: cover property (master_done);
    c_slave: cover property (slave_addr_valid);
    c_tea: cover property ($fell(transfer_error_ack_n_oe));
endmodule // lbus_port_sva

bind local_bus_address_arbitration_port lbus_port_sva u_lbus_port_sva (.mclk, .nrst, .master_start, .master_busy,
    .master_done, .addr_in, .addr_oe, .address_type_oe, .transfer_start_n, .bus_grant_n, .bus_request_n,
    .bus_busy_n_in, .bus_busy_n_out, .bus_busy_n_oe, .transfer_error_ack_n_out, .transfer_error_ack_n_oe,
    .slave_addr_valid, .slave_addr);

// file: dv/lbus_arbiter_model.sv
`timescale 1ns/1ps
module lbus_arbiter_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic bus_request_n,
    input wire logic slow,
    input wire logic other_own,
    input wire logic busy_oe,
    input wire logic busy_out,
    output logic bus_grant_n,
    output wire logic bus_busy_n
);
    logic [2:0] wait_cnt;
    // grant may come while another master still holds busy
    always_ff @(posedge mclk) begin
        if (!nrst || bus_request_n) begin
            wait_cnt <= 3'h0;
            bus_grant_n <= 1'b1;
        end else if (wait_cnt != (slow ? 3'h4 : 3'h0)) begin
            wait_cnt <= wait_cnt + 3'h1;
        end else begin
            bus_grant_n <= 1'b0;
        end
    end
    // pull-up when nobody drives
    assign bus_busy_n = busy_oe ? busy_out : ~other_own;
endmodule // lbus_arbiter_model

// file: dv/test_local_bus_address_arbitration_port.sv
`timescale 1ns/1ps
module test_local_bus_address_arbitration_port;
    import lbus_pkg::*;
    logic mclk = 0, nrst = 0, async_arbitration = 0, master_start = 0, beat_done = 0, transfer_start_n = 1;
    logic slow = 0, own = 0, slave_selected = 0, slave_error = 0, slave_end = 0, burst_data_in_progress_n_drv = 1, tea_drv = 1;
    logic rw_drv = 0;
    master_req_t master_req = '0;
    logic [addr_w-1:0] a_drv = '0, addr_out;
    logic [code_w-1:0] address_type;
    logic master_busy, master_error, master_done, addr_oe, address_type_oe, read_write_out, bus_grant_n;
    logic bus_request_n, bus_busy_n_out, bus_busy_n_oe, burst_data_in_progress_n_out, burst_data_in_progress_n_oe;
    logic transfer_error_ack_n_out, transfer_error_ack_n_oe, slave_addr_valid, slave_last_beat_next, second_family;
    slave_addr_t slave_addr;
    wire logic [addr_w-1:0] addr_in;
    wire logic bus_busy_n_in, burst_data_in_progress_n_in, transfer_error_ack_n_in;
    int fails = 0, checks_done = 0;
    always #2.5 mclk = ~mclk;
    assign addr_in = addr_oe ? addr_out : a_drv;
    assign burst_data_in_progress_n_in = burst_data_in_progress_n_oe ? burst_data_in_progress_n_out : burst_data_in_progress_n_drv;
    assign transfer_error_ack_n_in = transfer_error_ack_n_oe ? transfer_error_ack_n_out : tea_drv;
    local_bus_address_arbitration_port u_local_bus_address_arbitration_port (.mclk, .nrst, .async_arbitration,
        .master_start, .master_req, .beat_done, .master_busy, .master_error, .master_done, .addr_in, .addr_out,
        .addr_oe, .address_type, .address_type_oe, .transfer_start_n, .read_write_in(rw_drv), .read_write_out,
        .bus_grant_n, .bus_request_n, .bus_busy_n_in, .bus_busy_n_out, .bus_busy_n_oe, .burst_data_in_progress_n_in,
        .burst_data_in_progress_n_out, .burst_data_in_progress_n_oe, .transfer_error_ack_n_in,
        .transfer_error_ack_n_out, .transfer_error_ack_n_oe, .slave_selected, .slave_error, .slave_end,
        .slave_addr_valid, .slave_addr, .slave_last_beat_next, .second_family);
    lbus_arbiter_model u_lbus_arbiter_model (.mclk, .nrst, .bus_request_n, .slow, .other_own(own),
        .busy_oe(bus_busy_n_oe), .busy_out(bus_busy_n_out), .bus_grant_n, .bus_busy_n(bus_busy_n_in));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic timeout(logic hit);
        if (hit) begin
            fails++;
            $display("FAIL %0t: no response", $time);
            print_verdict();
        end
    endtask

    task automatic t_master(logic [31:0] a, logic rd, logic [2:0] nb, logic [2:0] expb, logic err, int hold);
        int i;
        int n;
        logic e;
        e = 0;
        n = err ? 1 : expb;
        master_req = '{addr: a, code: {rd, nb}, read: rd, beats: nb};
        own = hold != 0;
        master_start = 1;
        tick;
        master_start = 0;
        chk(bus_request_n, 0);
        chk(master_busy, 1);
        for (i = 0; i < hold; i++) begin
            tick;
            chk(addr_oe, 0);
        end
        own = 0;
        for (i = 0; i < 40 && addr_oe !== 1'b1; i++) tick;
        timeout(i == 40);
        chk(addr_out, rd ? {a[31:4], 4'h0} : a);
        chk(address_type, {rd, nb});
        chk(read_write_out, rd);
        chk(bus_busy_n_in, 0);
        if (!rd) chk(burst_data_in_progress_n_in, expb < 3'h2);
        for (i = 1; i <= n; i++) begin
            beat_done = 1;
            tea_drv = !err;
            tick;
            beat_done = 0;
            tea_drv = 1;
            e |= master_error === 1'b1;
            if (!rd && !err) chk(burst_data_in_progress_n_in, i >= n - 1);
            if (i < n) begin
                chk(master_done, 0);
                tick;
            end
        end
        for (i = 0; i < 8 && master_done !== 1'b1; i++) begin
            e |= master_error === 1'b1;
            tick;
        end
        e |= master_error === 1'b1;
        timeout(i == 8);
        chk(e, err);
        for (i = 0; i < 8 && bus_busy_n_oe !== 1'b0; i++) tick;
        timeout(i == 8);
        chk(addr_oe, 0);
        chk(bus_busy_n_in, 1);
        $display("master test ended");
    endtask

    task automatic t_slave;
        int i;
        transfer_start_n = 0;
        a_drv = 32'h5a5a_6c3d;
        rw_drv = 1;
        tick;
        transfer_start_n = 1;
        a_drv = ~a_drv;
        rw_drv = 0;
        chk(slave_addr_valid, 1);
        chk(slave_addr.read, 1);
        chk(slave_addr.addr, 32'h5a5a_6c3d);
        chk(slave_addr.offset, 12'hc3d);
        slave_selected = 1;
        slave_error = 1;
        burst_data_in_progress_n_drv = 0;
        repeat (2) tick;
        chk(transfer_error_ack_n_oe, 1);
        chk(transfer_error_ack_n_in, 0);
        chk(slave_last_beat_next, 1);
        slave_end = 1;
        burst_data_in_progress_n_drv = 1;
        tick;
        chk(transfer_error_ack_n_oe, 1);
        chk(transfer_error_ack_n_in, 1);
        for (i = 0; i < 8 && transfer_error_ack_n_oe !== 1'b0; i++) tick;
        timeout(i == 8);
        chk(transfer_error_ack_n_in, 1);
        slave_selected = 0;
        slave_error = 0;
        slave_end = 0;
        $display("slave test ended");
    endtask

    initial begin
        repeat (10) tick;
        nrst = 1;
        tick;
        chk(second_family, 1);
        t_master(32'h1000_0a34, 0, 3'h3, 3'h3, 0, 0);
        async_arbitration = 1;
        slow = 1;
        t_master(32'h2000_0b34, 1, 3'h2, 3'h4, 0, 6);
        async_arbitration = 0;
        slow = 0;
        t_master(32'h3000_0c38, 0, 3'h6, 3'h4, 1, 0);
        t_master(32'h4000_0d3c, 0, 3'h2, 3'h2, 0, 0);
        t_slave;
        nrst = 0;
        burst_data_in_progress_n_drv = 0;
        repeat (3) tick;
        nrst = 1;
        burst_data_in_progress_n_drv = 1;
        tick;
        chk(second_family, 0);
        print_verdict();
    end
endmodule // test_local_bus_address_arbitration_port
